//--- ext_bank_pkg.sv
package ext_bank_pkg;

    localparam int unsigned WORDS_PER_BANK = 6144;
    localparam int unsigned BANKS_MAX      = 3;
    localparam int unsigned BANK_W         = 2;
    localparam int unsigned WORD_W         = 13;
    localparam int unsigned INDEX_W        = 15;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned ORD_ADDR_W     = 16;
    localparam int unsigned COUNT_W        = 13;
    localparam int unsigned ORD_SPAN       = 65536;
    localparam logic [1:0]  RESET_BANK     = 2'h0;

    typedef enum logic [2:0] {
        OP_NONE        = 3'b000,
        OP_BANK_CHANGE = 3'b001,
        OP_CUR_XFER    = 3'b010,
        OP_EXP_XFER    = 3'b011,
        OP_STEER       = 3'b100
    } op_e;

    typedef enum logic {
        AREA_ORD = 1'b0,
        AREA_EXT = 1'b1
    } area_e;

    typedef struct packed {
        logic                    valid;
        op_e                     op;
        logic [BANK_W-1:0]       bank;
        logic                    steer_ext;
        area_e                   src_area;
        logic [ORD_ADDR_W-1:0]   src_addr;
        area_e                   dst_area;
        logic [BANK_W-1:0]       dst_bank;
        logic [ORD_ADDR_W-1:0]   dst_addr;
        logic [COUNT_W-1:0]      count;
    } cmd_s;

    typedef struct packed {
        logic                    req;
        logic                    we;
        logic [ORD_ADDR_W-1:0]   ptr;
        logic [DATA_W-1:0]       wdata;
    } ind_s;

    typedef struct packed {
        logic                    req;
        logic                    we;
        logic [ORD_ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]       wdata;
    } ord_s;

endpackage

//--- extended_memory_bank_select.sv
`timescale 1ns/1ps
module extended_memory_bank_select #(
    parameter int unsigned num_banks = 3
) (
    input  wire logic                                  clock,
    input  wire logic                                  rst,
    input  wire ext_bank_pkg::cmd_s                    cmd,
    input  wire logic                                  scan_start,
    input  wire logic                                  irq_enter,
    input  wire logic                                  irq_return,
    input  wire ext_bank_pkg::ind_s                    ind,
    input  wire logic [ext_bank_pkg::DATA_W-1:0]       ord_rdata,
    output ext_bank_pkg::ord_s                         ord,
    output logic [ext_bank_pkg::DATA_W-1:0]            ind_rdata,
    output logic                                       ind_ack,
    output logic                                       busy,
    output logic                                       op_error,
    output logic [ext_bank_pkg::BANK_W-1:0]            cur_bank,
    output logic                                       steer_active
);

    if (num_banks < 1 || num_banks > ext_bank_pkg::BANKS_MAX) begin : g_bad_banks
        $error("num_banks must be 1 to 3");
    end

    typedef enum logic [1:0] {
        XS_IDLE  = 2'b00,
        XS_READ  = 2'b01,
        XS_WAIT  = 2'b10,
        XS_WRITE = 2'b11
    } xfer_state_e;

    localparam int unsigned MEM_WORDS = num_banks * ext_bank_pkg::WORDS_PER_BANK;

    function automatic logic bank_ok(input logic [ext_bank_pkg::BANK_W-1:0] b);
        return 32'(b) < num_banks;
    endfunction

    // flat index of a word across all banks of the array
    function automatic logic [ext_bank_pkg::INDEX_W-1:0] ext_index(
        input logic [ext_bank_pkg::BANK_W-1:0]     b,
        input logic [ext_bank_pkg::ORD_ADDR_W-1:0] w
    );
        return ext_bank_pkg::INDEX_W'(32'(b) * ext_bank_pkg::WORDS_PER_BANK + 32'(w));
    endfunction

    // a block must stay inside its bank or the ordinary store
    function automatic logic span_ok(
        input ext_bank_pkg::area_e                 a,
        input logic [ext_bank_pkg::ORD_ADDR_W-1:0] addr,
        input logic [ext_bank_pkg::COUNT_W-1:0]    n
    );
        logic [31:0] top;
        top = 32'(addr) + 32'(n);
        if (n == '0) return 1'b0;
        if (a == ext_bank_pkg::AREA_EXT) return top <= ext_bank_pkg::WORDS_PER_BANK;
        return top <= ext_bank_pkg::ORD_SPAN;
    endfunction

    logic [ext_bank_pkg::DATA_W-1:0] mem [MEM_WORDS];
    logic [ext_bank_pkg::DATA_W-1:0] mem_q;
    logic                            mem_we;
    logic                            mem_re;
    logic [ext_bank_pkg::INDEX_W-1:0] mem_waddr;
    logic [ext_bank_pkg::INDEX_W-1:0] mem_raddr;
    logic [ext_bank_pkg::DATA_W-1:0] mem_wdata;

    xfer_state_e                      xs, next_xs;
    ext_bank_pkg::area_e              src_area, next_src_area;
    ext_bank_pkg::area_e              dst_area, next_dst_area;
    logic [ext_bank_pkg::BANK_W-1:0]  src_bank, next_src_bank;
    logic [ext_bank_pkg::BANK_W-1:0]  dst_bank, next_dst_bank;
    logic [ext_bank_pkg::ORD_ADDR_W-1:0] src_addr, next_src_addr;
    logic [ext_bank_pkg::ORD_ADDR_W-1:0] dst_addr, next_dst_addr;
    logic [ext_bank_pkg::COUNT_W-1:0] remain, next_remain;

    logic [ext_bank_pkg::BANK_W-1:0]  next_cur_bank;
    logic                             next_steer_active;
    logic [ext_bank_pkg::BANK_W-1:0]  steer_bank, next_steer_bank;
    logic                             shadow_active, next_shadow_active;
    logic [ext_bank_pkg::BANK_W-1:0]  shadow_bank, next_shadow_bank;

    logic                             pend_ext, next_pend_ext;
    logic                             pend_ord1, next_pend_ord1;
    logic                             pend_ord2, next_pend_ord2;
    ext_bank_pkg::ord_s               next_ord;
    logic [ext_bank_pkg::DATA_W-1:0]  next_ind_rdata;
    logic                             next_ind_ack;
    logic                             next_busy;
    logic                             next_op_error;

    logic                             any_event;
    logic                             accept;
    logic [ext_bank_pkg::DATA_W-1:0]  xfer_data;

    always_comb begin
        next_xs            = xs;
        next_src_area      = src_area;
        next_dst_area      = dst_area;
        next_src_bank      = src_bank;
        next_dst_bank      = dst_bank;
        next_src_addr      = src_addr;
        next_dst_addr      = dst_addr;
        next_remain        = remain;
        next_cur_bank      = cur_bank;
        next_steer_active  = steer_active;
        next_steer_bank    = steer_bank;
        next_shadow_active = shadow_active;
        next_shadow_bank   = shadow_bank;
        next_pend_ext      = 1'b0;
        next_pend_ord1     = 1'b0;
        next_pend_ord2     = pend_ord1;
        next_ord           = '0;
        next_ind_rdata     = ind_rdata;
        next_ind_ack       = 1'b0;
        next_op_error      = 1'b0;
        mem_we             = 1'b0;
        mem_re             = 1'b0;
        mem_waddr          = '0;
        mem_raddr          = '0;
        mem_wdata          = '0;
        xfer_data          = (src_area == ext_bank_pkg::AREA_EXT) ? mem_q : ord_rdata;
        any_event          = scan_start | irq_enter | irq_return;
        // commands are taken only when idle and no scan or interrupt event is pending
        accept             = cmd.valid && (xs == XS_IDLE) && !any_event;

        if (irq_return) begin
            next_steer_active = shadow_active;
            next_steer_bank   = shadow_bank;
        end else if (irq_enter) begin
            next_shadow_active = steer_active;
            next_shadow_bank   = steer_bank;
            next_steer_active  = 1'b0;
        end else if (scan_start) begin
            next_steer_active = 1'b0;
        end
        // cur_bank deliberately left alone by all three events

        if (accept) begin
            unique case (cmd.op)
                ext_bank_pkg::OP_BANK_CHANGE: begin
                    if (bank_ok(cmd.bank)) next_cur_bank = cmd.bank;
                    else next_op_error = 1'b1;
                end
                ext_bank_pkg::OP_STEER: begin
                    if (!cmd.steer_ext) begin
                        next_steer_active = 1'b0;
                    end else if (bank_ok(cmd.bank)) begin
                        next_steer_active = 1'b1;
                        next_steer_bank   = cmd.bank;
                        next_cur_bank     = cmd.bank;
                    end else begin
                        next_op_error = 1'b1;
                    end
                end
                ext_bank_pkg::OP_CUR_XFER, ext_bank_pkg::OP_EXP_XFER: begin
                    next_src_area = cmd.src_area;
                    next_dst_area = cmd.dst_area;
                    next_src_addr = cmd.src_addr;
                    next_dst_addr = cmd.dst_addr;
                    next_remain   = cmd.count;
                    if (cmd.op == ext_bank_pkg::OP_CUR_XFER) begin
                        // both ends use the current bank
                        next_src_bank = cur_bank;
                        next_dst_bank = cur_bank;
                    end else begin
                        next_src_bank = cmd.bank;
                        next_dst_bank = cmd.dst_bank;
                    end
                    if (cmd.src_area != ext_bank_pkg::AREA_EXT && cmd.dst_area != ext_bank_pkg::AREA_EXT) begin
                        next_op_error = 1'b1;
                    end else if (!bank_ok(next_src_bank) || !bank_ok(next_dst_bank) ||
                                 !span_ok(cmd.src_area, cmd.src_addr, cmd.count) ||
                                 !span_ok(cmd.dst_area, cmd.dst_addr, cmd.count)) begin
                        next_op_error = 1'b1;
                    end else begin
                        next_xs = XS_READ;
                    end
                end
                default: ;
            endcase
        end

        // extended array is reached only by transfer and steered indirect paths
        unique case (xs)
            XS_IDLE: begin
                if (ind.req) begin
                    if (steer_active) begin
                        // steered indirect stays in the bank
                        next_pend_ext = 1'b1;
                        if (ind.we) begin
                            mem_we    = 1'b1;
                            mem_waddr = ext_index(steer_bank, ind.ptr);
                            mem_wdata = ind.wdata;
                        end else begin
                            mem_re    = 1'b1;
                            mem_raddr = ext_index(steer_bank, ind.ptr);
                        end
                    end else begin
                        next_pend_ord1 = 1'b1;
                        next_ord.req   = 1'b1;
                        next_ord.we    = ind.we;
                        next_ord.addr  = ind.ptr;
                        next_ord.wdata = ind.wdata;
                    end
                end
            end
            XS_READ: begin
                if (src_area == ext_bank_pkg::AREA_EXT) begin
                    mem_re    = 1'b1;
                    mem_raddr = ext_index(src_bank, src_addr);
                end else begin
                    next_ord.req  = 1'b1;
                    next_ord.addr = src_addr;
                end
                next_xs = XS_WAIT;
            end
            XS_WAIT: next_xs = XS_WRITE;
            XS_WRITE: begin
                if (dst_area == ext_bank_pkg::AREA_EXT) begin
                    mem_we    = 1'b1;
                    mem_waddr = ext_index(dst_bank, dst_addr);
                    mem_wdata = xfer_data;
                end else begin
                    next_ord.req   = 1'b1;
                    next_ord.we    = 1'b1;
                    next_ord.addr  = dst_addr;
                    next_ord.wdata = xfer_data;
                end
                next_src_addr = src_addr + 1'b1;
                next_dst_addr = dst_addr + 1'b1;
                next_remain   = remain - 1'b1;
                next_xs       = (remain == ext_bank_pkg::COUNT_W'(1)) ? XS_IDLE : XS_READ;
            end
        endcase

        if (pend_ext) begin
            next_ind_rdata = mem_q;
            next_ind_ack   = 1'b1;
        end else if (pend_ord2) begin
            next_ind_rdata = ord_rdata;
            next_ind_ack   = 1'b1;
        end
        next_busy = (next_xs != XS_IDLE);
    end

    // array has no reset; its contents are data, not control
    always_ff @(posedge clock) begin
        if (mem_we) mem[mem_waddr] <= mem_wdata;
        if (mem_re) mem_q <= mem[mem_raddr];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            xs            <= XS_IDLE;
            src_area      <= ext_bank_pkg::AREA_ORD;
            dst_area      <= ext_bank_pkg::AREA_ORD;
            src_bank      <= '0;
            dst_bank      <= '0;
            src_addr      <= '0;
            dst_addr      <= '0;
            remain        <= '0;
            cur_bank      <= ext_bank_pkg::RESET_BANK;
            steer_active  <= 1'b0;
            steer_bank    <= '0;
            shadow_active <= 1'b0;
            shadow_bank   <= '0;
            pend_ext      <= 1'b0;
            pend_ord1     <= 1'b0;
            pend_ord2     <= 1'b0;
            ord           <= '0;
            ind_rdata     <= '0;
            ind_ack       <= 1'b0;
            busy          <= 1'b0;
            op_error      <= 1'b0;
        end else begin
            xs            <= next_xs;
            src_area      <= next_src_area;
            dst_area      <= next_dst_area;
            src_bank      <= next_src_bank;
            dst_bank      <= next_dst_bank;
            src_addr      <= next_src_addr;
            dst_addr      <= next_dst_addr;
            remain        <= next_remain;
            // bank only ever moves by operation, so it survives mode and interrupt changes
            cur_bank      <= next_cur_bank;
            steer_active  <= next_steer_active;
            steer_bank    <= next_steer_bank;
            shadow_active <= next_shadow_active;
            shadow_bank   <= next_shadow_bank;
            pend_ext      <= next_pend_ext;
            pend_ord1     <= next_pend_ord1;
            pend_ord2     <= next_pend_ord2;
            ord           <= next_ord;
            ind_rdata     <= next_ind_rdata;
            ind_ack       <= next_ind_ack;
            busy          <= next_busy;
            op_error      <= next_op_error;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_bank_range: assert property (32'(cur_bank) < num_banks)
        else $error("current bank beyond fitted banks");
    a_bank_change: assert property (accept && cmd.op == ext_bank_pkg::OP_BANK_CHANGE && bank_ok(cmd.bank)
        |=> cur_bank == $past(cmd.bank)) else $error("bank change not loaded");
    a_steer_bank: assert property (accept && cmd.op == ext_bank_pkg::OP_STEER && cmd.steer_ext
        && bank_ok(cmd.bank) |=> steer_active && cur_bank == $past(cmd.bank)) else $error("steer did not set bank");
    a_steer_off: assert property (accept && cmd.op == ext_bank_pkg::OP_STEER && !cmd.steer_ext
        |=> !steer_active) else $error("steer 000 did not clear");
    a_steer_route: assert property (xs == XS_IDLE && ind.req && steer_active
        |=> !ord.req ##1 ind_ack) else $error("steered access leaked to ordinary store");
    a_scan_clear: assert property (scan_start && !irq_return && !irq_enter |=> !steer_active)
        else $error("scan start kept steering");
    a_irq_force: assert property (irq_enter && !irq_return |=> !steer_active
        && shadow_active == $past(steer_active)) else $error("interrupt entry kept steering");
    a_irq_restore: assert property (irq_return |=> steer_active == $past(shadow_active)
        && steer_bank == $past(shadow_bank)) else $error("interrupt return lost steering");
    a_bank_keep: assert property (any_event || (accept && cmd.op == ext_bank_pkg::OP_EXP_XFER)
        |=> $stable(cur_bank)) else $error("current bank changed by event");

endmodule // extended_memory_bank_select

//--- ord_store_model.sv
`timescale 1ns/1ps
module ord_store_model (
    input  wire logic                              clock,
    input  wire ext_bank_pkg::ord_s                ord,
    output logic [ext_bank_pkg::DATA_W-1:0]        ord_rdata
);
    logic [ext_bank_pkg::DATA_W-1:0] mem [0:ext_bank_pkg::ORD_SPAN-1];

    initial begin
        for (int i = 0; i < ext_bank_pkg::ORD_SPAN; i++) begin
            mem[i] = 16'(i) ^ 16'ha5c3;
        end
        ord_rdata = 16'h0000;
    end

    // read data is good for one cycle only; otherwise the line toggles so a late capture shows up
    always @(posedge clock) begin
        if (ord.req && !ord.we) begin
            ord_rdata <= mem[ord.addr];
        end else begin
            ord_rdata <= ~ord_rdata;
        end
        if (ord.req && ord.we) begin
            mem[ord.addr] <= ord.wdata;
        end
    end
endmodule // ord_store_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam ext_bank_pkg::area_e ao = ext_bank_pkg::AREA_ORD;
    localparam ext_bank_pkg::area_e ax = ext_bank_pkg::AREA_EXT;
    localparam ext_bank_pkg::op_e   op_bc = ext_bank_pkg::OP_BANK_CHANGE;
    localparam ext_bank_pkg::op_e   op_cx = ext_bank_pkg::OP_CUR_XFER;
    localparam ext_bank_pkg::op_e   op_ex = ext_bank_pkg::OP_EXP_XFER;
    localparam ext_bank_pkg::op_e   op_st = ext_bank_pkg::OP_STEER;

    logic                             clock;
    logic                             rst;
    ext_bank_pkg::cmd_s               cmd;
    logic                             scan_start;
    logic                             irq_enter;
    logic                             irq_return;
    ext_bank_pkg::ind_s               ind;
    logic [ext_bank_pkg::DATA_W-1:0]  ord_rdata;
    ext_bank_pkg::ord_s               ord;
    logic [ext_bank_pkg::DATA_W-1:0]  ind_rdata;
    logic                             ind_ack;
    logic                             busy;
    logic                             op_error;
    logic [ext_bank_pkg::BANK_W-1:0]  cur_bank;
    logic                             steer_active;
    int                               miscompares;
    int                               n_checks;
    logic [15:0]                      rd;

    extended_memory_bank_select #(.num_banks(3)) uut (
        .clock(clock), .rst(rst), .cmd(cmd), .scan_start(scan_start), .irq_enter(irq_enter),
        .irq_return(irq_return), .ind(ind), .ord_rdata(ord_rdata), .ord(ord), .ind_rdata(ind_rdata),
        .ind_ack(ind_ack), .busy(busy), .op_error(op_error), .cur_bank(cur_bank), .steer_active(steer_active)
    );

    ord_store_model store (.clock(clock), .ord(ord), .ord_rdata(ord_rdata));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    function automatic logic [15:0] fill(input int a);
        return 16'(a) ^ 16'ha5c3;
    endfunction

    function automatic ext_bank_pkg::cmd_s mk(input ext_bank_pkg::op_e op, input logic [1:0] bk,
        input logic ext, input ext_bank_pkg::area_e sa, input logic [15:0] sad,
        input ext_bank_pkg::area_e da, input logic [15:0] dad, input logic [12:0] n);
        ext_bank_pkg::cmd_s c;
        c = '0;
        c.valid = 1'b1;
        c.op = op;
        c.bank = bk;
        c.steer_ext = ext;
        c.src_area = sa;
        c.src_addr = sad;
        c.dst_area = da;
        c.dst_addr = dad;
        c.count = n;
        return c;
    endfunction

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send(input ext_bank_pkg::cmd_s c, input logic err);
        cmd = c;
        tick();
        cmd.valid = 1'b0;
        check({15'h0, op_error}, {15'h0, err});
        // one idle edge so the next request never lands in this time step
        tick();
    endtask

    // wait is bounded a few cycles past three per word
    task automatic xfer(input ext_bank_pkg::cmd_s c);
        int n;
        send(c, 1'b0);
        check({15'h0, busy}, 16'h0001);
        n = 0;
        while (busy && n < 3 * int'(c.count) + 4) begin
            tick();
            n++;
        end
        check({15'h0, busy}, 16'h0000);
        if (busy) finish_test();
        tick();
        tick();
    endtask

    // lat 2 means steered route, 3 means ordinary store route
    task automatic ind_op(input logic we, input logic [15:0] ptr, input logic [15:0] wd, input int lat);
        int   n;
        logic seen;
        ind = '{req: 1'b1, we: we, ptr: ptr, wdata: wd};
        tick();
        // request lowered once only, so a following call may raise it at the end time
        ind.req = 1'b0;
        n = 1;
        seen = (ord.req === 1'b1);
        while (ind_ack !== 1'b1 && n < 8) begin
            tick();
            n++;
            seen = seen | (ord.req === 1'b1);
        end
        check(16'(n), 16'(lat));
        check({15'h0, seen}, {15'h0, lat == 3});
        if (ind_ack !== 1'b1) finish_test();
        rd = ind_rdata;
    endtask

    task automatic test_bank();
        check({14'h0, cur_bank}, 16'h0000);
        send(mk(op_bc, 2'h2, 1'b0, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        check({14'h0, cur_bank}, 16'h0002);
        send(mk(op_bc, 2'h1, 1'b0, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        check({14'h0, cur_bank}, 16'h0001);
        send(mk(op_bc, 2'h3, 1'b0, ao, 16'h0, ao, 16'h0, 13'h0), 1'b1);
        check({14'h0, cur_bank}, 16'h0001);
    endtask

    task automatic test_steer();
        send(mk(op_st, 2'h2, 1'b1, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        check({15'h0, steer_active}, 16'h0001);
        check({14'h0, cur_bank}, 16'h0002);
        ind_op(1'b1, 16'h0100, 16'h1234, 2);
        check(store.mem[16'h0100], fill(16'h0100));
        ind_op(1'b0, 16'h0100, 16'h0000, 2);
        check(rd, 16'h1234);
        send(mk(op_st, 2'h0, 1'b0, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        check({15'h0, steer_active}, 16'h0000);
        ind_op(1'b0, 16'h0100, 16'h0000, 3);
        check(rd, fill(16'h0100));
    endtask

    task automatic test_events();
        send(mk(op_st, 2'h1, 1'b1, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        scan_start = 1'b1;
        tick();
        scan_start = 1'b0;
        check({15'h0, steer_active}, 16'h0000);
        check({14'h0, cur_bank}, 16'h0001);
        send(mk(op_st, 2'h2, 1'b1, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        irq_enter = 1'b1;
        tick();
        irq_enter = 1'b0;
        check({15'h0, steer_active}, 16'h0000);
        check({14'h0, cur_bank}, 16'h0002);
        ind_op(1'b0, 16'h0100, 16'h0000, 3);
        irq_return = 1'b1;
        tick();
        irq_return = 1'b0;
        check({15'h0, steer_active}, 16'h0001);
        check({14'h0, cur_bank}, 16'h0002);
        ind_op(1'b0, 16'h0100, 16'h0000, 2);
        check(rd, 16'h1234);
        send(mk(op_st, 2'h0, 1'b0, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
    endtask

    task automatic test_xfer();
        send(mk(op_bc, 2'h1, 1'b0, ao, 16'h0, ao, 16'h0, 13'h0), 1'b0);
        xfer(mk(op_cx, 2'h0, 1'b0, ao, 16'h0010, ax, 16'd6142, 13'h2));
        xfer(mk(op_ex, 2'h1, 1'b0, ax, 16'd6142, ao, 16'h0200, 13'h2));
        check(store.mem[16'h0200], fill(16'h0010));
        check(store.mem[16'h0201], fill(16'h0011));
        xfer(mk(op_ex, 2'h2, 1'b0, ax, 16'h0100, ao, 16'h0300, 13'h1));
        check(store.mem[16'h0300], 16'h1234);
        check({14'h0, cur_bank}, 16'h0001);
        send(mk(op_cx, 2'h0, 1'b0, ao, 16'h0010, ao, 16'h0020, 13'h1), 1'b1);
        send(mk(op_cx, 2'h0, 1'b0, ao, 16'h0010, ax, 16'h0020, 13'h0), 1'b1);
        send(mk(op_cx, 2'h0, 1'b0, ao, 16'h0010, ax, 16'd6143, 13'h2), 1'b1);
        send(mk(op_ex, 2'h3, 1'b0, ax, 16'h0000, ao, 16'h0020, 13'h1), 1'b1);
        check({15'h0, busy}, 16'h0000);
    endtask

    initial begin
        miscompares = 0;
        n_checks = 0;
        rst = 1'b1;
        cmd = '0;
        scan_start = 1'b0;
        irq_enter = 1'b0;
        irq_return = 1'b0;
        ind = '0;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        test_bank();
        test_steer();
        test_events();
        test_xfer();
        finish_test();
    end
endmodule // testbench
